// >>> include/mdu_pkg.sv
// Shared constants and types for the multiply/divide unit
package mdu_pkg;
   // ==========================================================
   // Widths
   localparam int DATA_W   = 32;
   localparam int HALF_W   = 16;
   localparam int REGSEL_W = 4;
   localparam int CNT_W    = 4;

   // ==========================================================
   // Register numbers the issuer must keep out of operand fields
   localparam logic [3:0] STACK_POINTER_REG   = 4'hD;
   localparam logic [3:0] PROGRAM_COUNTER_REG = 4'hF;

   // ==========================================================
   // Divide timing: least and most cycles from issue to write-back
   localparam int DIV_MIN_CYC = 2;
   localparam int DIV_MAX_CYC = 11;
   // Quotient bits retired per iteration (32 / 4 = 8 steps, +3 setup/fix)
   localparam int DIV_RADIX_BITS = 4;
   localparam int DIV_STEPS      = DATA_W / DIV_RADIX_BITS;

   // ==========================================================
   // Reset values
   localparam logic [31:0] RESULT_RST = 32'h0000_0000;

   // ==========================================================
   // Operation codes
   typedef enum logic [3:0] {
      OP_MULT_LOW_WORD          = 4'h0,
      OP_MULT_LOW_WORD_SETFLAGS = 4'h1,
      OP_MULT_ACCUMULATE        = 4'h2,
      OP_MULT_SUBTRACT          = 4'h3,
      OP_SIGNED_DIVIDE          = 4'h4,
      OP_UNSIGNED_DIVIDE        = 4'h5,
      OP_HALFMAC_BOT_BOT        = 4'h6,
      OP_HALFMAC_BOT_TOP        = 4'h7,
      OP_HALFMAC_TOP_BOT        = 4'h8,
      OP_HALFMAC_TOP_TOP        = 4'h9,
      OP_WORDHALF_MAC_BOT       = 4'hA,
      OP_WORDHALF_MAC_TOP       = 4'hB
   } mdu_op_t;
endpackage : mdu_pkg

// >>> src/mdu_divider.sv
// Iterative radix-16 divider core, signed and unsigned
`timescale 1ns/10ps
module mdu_divider #(
   parameter int W = mdu_pkg::DATA_W
) (
   input  wire logic         clk_sys,
   input  wire logic         resetn,
   input  wire logic         start,
   input  wire logic         is_signed,
   input  wire logic [W-1:0] dividend,
   input  wire logic [W-1:0] divisor,
   output logic              busy,
   output logic              done,
   output logic [W-1:0]      quotient
);
   // ==========================================================
   // State
   typedef enum logic [1:0] {MDD_IDLE, MDD_RUN, MDD_FIX} mdd_state_t;

   mdd_state_t         state_reg, state_next;
   logic [W-1:0]       rem_reg,  rem_next;
   logic [W-1:0]       quo_reg,  quo_next;
   logic [W-1:0]       dsr_reg,  dsr_next;
   logic [W-1:0]       res_reg,  res_next;
   logic               neg_reg,  neg_next;
   logic               done_reg, done_next;
   logic [mdu_pkg::CNT_W-1:0] cnt_reg, cnt_next;

   function automatic logic [W-1:0] mag(input logic [W-1:0] v,
                                        input logic sgn);
      mag = (sgn && v[W-1]) ? W'(-v) : v;
   endfunction : mag

   // ==========================================================
   // Next state
   always_comb begin
      logic [W:0]   r;
      logic [W-1:0] q;
      logic [W-1:0] a;
      logic [W-1:0] b;
      r          = '0;
      q          = quo_reg;
      a          = mag(dividend, is_signed);
      b          = mag(divisor, is_signed);
      state_next = state_reg;
      rem_next   = rem_reg;
      quo_next   = quo_reg;
      dsr_next   = dsr_reg;
      res_next   = res_reg;
      neg_next   = neg_reg;
      cnt_next   = cnt_reg;
      done_next  = 1'b0;
      case (state_reg)
         MDD_IDLE: begin
            if (start) begin
               neg_next = is_signed && (dividend[W-1] ^ divisor[W-1]);
               dsr_next = b;
               rem_next = '0;
               quo_next = a;
               cnt_next = '0;
               // Zero divisor or small dividend: finish early
               if (b == '0 || a < b) begin
                  res_next   = '0;
                  done_next  = 1'b1;
               end else begin
                  state_next = MDD_RUN;
               end
            end
         end
         MDD_RUN: begin
            // Four restoring steps per clock keeps latency in bounds
            r = {1'b0, rem_reg};
            for (int i = 0; i < mdu_pkg::DIV_RADIX_BITS; i++) begin
               r = {r[W-1:0], q[W-1]};
               q = {q[W-2:0], 1'b0};
               if (r >= {1'b0, dsr_reg}) begin
                  r    = r - {1'b0, dsr_reg};
                  q[0] = 1'b1;
               end
            end
            rem_next = r[W-1:0];
            quo_next = q;
            cnt_next = cnt_reg + 1'b1;
            if (cnt_reg == mdu_pkg::CNT_W'(mdu_pkg::DIV_STEPS - 1)) begin
               state_next = MDD_FIX;
            end
         end
         default: begin
            // Magnitude quotient already truncates toward zero
            res_next   = neg_reg ? W'(-quo_reg) : quo_reg;
            done_next  = 1'b1;
            state_next = MDD_IDLE;
         end
      endcase
   end

   // ==========================================================
   // Registers
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         state_reg <= MDD_IDLE;
         rem_reg   <= '0;
         quo_reg   <= '0;
         dsr_reg   <= '0;
         res_reg   <= '0;
         neg_reg   <= 1'b0;
         cnt_reg   <= '0;
         done_reg  <= 1'b0;
      end else begin
         state_reg <= state_next;
         rem_reg   <= rem_next;
         quo_reg   <= quo_next;
         dsr_reg   <= dsr_next;
         res_reg   <= res_next;
         neg_reg   <= neg_next;
         cnt_reg   <= cnt_next;
         done_reg  <= done_next;
      end
   end

   assign busy     = (state_reg != MDD_IDLE);
   assign done     = done_reg;
   assign quotient = res_reg;
endmodule : mdu_divider

// >>> src/mdu_unit.sv
// Multiply, multiply-accumulate and divide datapath of the core
`timescale 1ns/10ps
module mdu_unit #(
   parameter int W  = mdu_pkg::DATA_W,
   parameter int RW = mdu_pkg::REGSEL_W
) (
   input  wire logic          clk_sys,
   input  wire logic          resetn,
   input  wire logic          issue_valid,
   input  wire logic [3:0]    issue_op,
   input  wire logic          cond_pass,
   input  wire logic          dest_given,
   input  wire logic [RW-1:0] dest_sel,
   input  wire logic [RW-1:0] first_operand_sel,
   input  wire logic [W-1:0]  first_operand_reg,
   input  wire logic [W-1:0]  second_operand_reg,
   input  wire logic [W-1:0]  accum_operand_reg,
   output logic              issue_ready,
   output logic              wr_en,
   output logic [RW-1:0]     wr_sel,
   output logic [W-1:0]      wr_data,
   output logic              flag_nz_we,
   output logic              flag_n,
   output logic              flag_z,
   output logic              flag_q_set
);
   // ==========================================================
   // Issue decode
   mdu_pkg::mdu_op_t op;
   logic             go;
   logic             is_div;
   logic             div_busy;
   logic             div_done;
   logic [W-1:0]     div_quo;
   logic [RW-1:0]    tgt_sel;
   logic             pend_reg, pend_next;
   logic [RW-1:0]    dsel_reg, dsel_next;

   assign op     = mdu_pkg::mdu_op_t'(issue_op);
   assign is_div = (op == mdu_pkg::OP_SIGNED_DIVIDE) ||
                   (op == mdu_pkg::OP_UNSIGNED_DIVIDE);
   // Failed condition still consumes the issue slot
   assign go     = issue_valid && issue_ready && cond_pass;
   // Divides stall the issuer; single-cycle ops accepted whenever no divide is pending
   assign issue_ready = !div_busy && !pend_reg;
   assign tgt_sel = dest_given ? dest_sel : first_operand_sel;

   // ==========================================================
   // Helpers
   function automatic logic [W-1:0] half_pick(input logic [W-1:0] v,
                                              input logic top);
      half_pick = top ? {{(W-16){v[W-1]}}, v[W-1:16]}
                      : {{(W-16){v[15]}}, v[15:0]};
   endfunction : half_pick

   function automatic logic sat_add(input logic [W-1:0] a,
                                    input logic [W-1:0] b,
                                    output logic [W-1:0] s);
      s       = W'(a + b);
      sat_add = (a[W-1] == b[W-1]) && (s[W-1] != a[W-1]);
   endfunction : sat_add

   // ==========================================================
   // Combinational result
   logic [W-1:0]     prod_lo;
   logic [W-1:0]     mac_res;
   logic             mac_ovf;
   logic [47:0]      wide_prod;
   logic [W-1:0]     hprod;

   // Low word of the product is sign-agnostic, so one multiplier serves
   assign prod_lo = W'(first_operand_reg * second_operand_reg);

   always_comb begin
      logic [W-1:0] ha;
      logic [W-1:0] hb;
      ha        = '0;
      hb        = '0;
      hprod     = '0;
      wide_prod = '0;
      mac_res   = '0;
      mac_ovf   = 1'b0;
      case (op)
         mdu_pkg::OP_MULT_LOW_WORD,
         mdu_pkg::OP_MULT_LOW_WORD_SETFLAGS: begin
            mac_res = prod_lo;
         end
         mdu_pkg::OP_MULT_ACCUMULATE: begin
            mac_res = W'(accum_operand_reg + prod_lo);
         end
         mdu_pkg::OP_MULT_SUBTRACT: begin
            mac_res = W'(accum_operand_reg - prod_lo);
         end
         mdu_pkg::OP_HALFMAC_BOT_BOT, mdu_pkg::OP_HALFMAC_BOT_TOP,
         mdu_pkg::OP_HALFMAC_TOP_BOT, mdu_pkg::OP_HALFMAC_TOP_TOP: begin
            ha = half_pick(first_operand_reg,
                           op == mdu_pkg::OP_HALFMAC_TOP_BOT ||
                           op == mdu_pkg::OP_HALFMAC_TOP_TOP);
            hb = half_pick(second_operand_reg,
                           op == mdu_pkg::OP_HALFMAC_BOT_TOP ||
                           op == mdu_pkg::OP_HALFMAC_TOP_TOP);
            // 16x16 signed never overflows 32 bits
            hprod   = W'($signed(ha) * $signed(hb));
            mac_ovf = sat_add(hprod, accum_operand_reg, mac_res);
         end
         mdu_pkg::OP_WORDHALF_MAC_BOT,
         mdu_pkg::OP_WORDHALF_MAC_TOP: begin
            hb = half_pick(second_operand_reg,
                           op == mdu_pkg::OP_WORDHALF_MAC_TOP);
            // Both factors sign-extended to 48 bits before multiplying
            wide_prod = 48'($signed(first_operand_reg)) *
                        48'($signed(hb));
            hprod   = wide_prod[47:16];
            mac_ovf = sat_add(hprod, accum_operand_reg, mac_res);
         end
         default: begin
            mac_res = '0;
         end
      endcase
   end

   // ==========================================================
   // Divider
   mdu_divider #(.W(W)) u_div (
      .clk_sys   (clk_sys),
      .resetn    (resetn),
      .start     (go && is_div),
      .is_signed (op == mdu_pkg::OP_SIGNED_DIVIDE),
      .dividend  (first_operand_reg),
      .divisor   (second_operand_reg),
      .busy      (div_busy),
      .done      (div_done),
      .quotient  (div_quo)
   );

   // ==========================================================
   // Write-back registers
   logic          wr_en_reg,  wr_en_next;
   logic [RW-1:0] wr_sel_reg, wr_sel_next;
   logic [W-1:0]  wr_dat_reg, wr_dat_next;
   logic          nzwe_reg,   nzwe_next;
   logic          n_reg,      n_next;
   logic          z_reg,      z_next;
   logic          q_reg,      q_next;

   always_comb begin
      pend_next   = pend_reg;
      dsel_next   = dsel_reg;
      wr_en_next  = 1'b0;
      wr_sel_next = wr_sel_reg;
      wr_dat_next = wr_dat_reg;
      nzwe_next   = 1'b0;
      n_next      = n_reg;
      z_next      = z_reg;
      q_next      = 1'b0;
      if (go && is_div) begin
         // Hold destination until quotient returns; no flags touched
         pend_next = 1'b1;
         dsel_next = tgt_sel;
      end else if (go) begin
         wr_en_next  = 1'b1;
         wr_sel_next = tgt_sel;
         wr_dat_next = mac_res;
         q_next      = mac_ovf;
         if (op == mdu_pkg::OP_MULT_LOW_WORD_SETFLAGS) begin
            nzwe_next = 1'b1;
            n_next    = mac_res[W-1];
            z_next    = (mac_res == '0);
         end
      end
      if (pend_reg && div_done) begin
         pend_next   = 1'b0;
         wr_en_next  = 1'b1;
         wr_sel_next = dsel_reg;
         wr_dat_next = div_quo;
      end
   end

   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         pend_reg   <= 1'b0;
         dsel_reg   <= '0;
         wr_en_reg  <= 1'b0;
         wr_sel_reg <= '0;
         wr_dat_reg <= mdu_pkg::RESULT_RST;
         nzwe_reg   <= 1'b0;
         n_reg      <= 1'b0;
         z_reg      <= 1'b0;
         q_reg      <= 1'b0;
      end else begin
         pend_reg   <= pend_next;
         dsel_reg   <= dsel_next;
         wr_en_reg  <= wr_en_next;
         wr_sel_reg <= wr_sel_next;
         wr_dat_reg <= wr_dat_next;
         nzwe_reg   <= nzwe_next;
         n_reg      <= n_next;
         z_reg      <= z_next;
         q_reg      <= q_next;
      end
   end

   assign wr_en      = wr_en_reg;
   assign wr_sel     = wr_sel_reg;
   assign wr_data    = wr_dat_reg;
   assign flag_nz_we = nzwe_reg;
   assign flag_n     = n_reg;
   assign flag_z     = z_reg;
   assign flag_q_set = q_reg;
endmodule : mdu_unit

// >>> sim/mdu_unit_checker.sv
// Assertions on the ports of the multiply/divide unit
`timescale 1ns/10ps
module mdu_unit_checker #(
   parameter int W  = 32,
   parameter int RW = 4
) (
   input wire logic          clk_sys,
   input wire logic          resetn,
   input wire logic          issue_valid,
   input wire logic [3:0]    issue_op,
   input wire logic          cond_pass,
   input wire logic          dest_given,
   input wire logic [RW-1:0] dest_sel,
   input wire logic [RW-1:0] first_operand_sel,
   input wire logic [W-1:0]  first_operand_reg,
   input wire logic [W-1:0]  second_operand_reg,
   input wire logic [W-1:0]  accum_operand_reg,
   input wire logic          issue_ready,
   input wire logic          wr_en,
   input wire logic [RW-1:0] wr_sel,
   input wire logic [W-1:0]  wr_data,
   input wire logic          flag_nz_we,
   input wire logic          flag_n,
   input wire logic          flag_z,
   input wire logic          flag_q_set
);
   logic take;
   logic go;
   logic dv;
   assign take = issue_valid && issue_ready;
   assign go = take && cond_pass;
   assign dv = issue_op == 4'h4 || issue_op == 4'h5;
   default clocking cb @(posedge clk_sys);
   endclocking
   default disable iff (!resetn);
   mul_low_a: assert property (
      go && issue_op == 4'h0 |=> wr_en
      && wr_data == $past(first_operand_reg) * $past(second_operand_reg))
      else $error("multiply result wrong");
   mac_sum_a: assert property (
      go && issue_op == 4'h2 |=> wr_data == $past(accum_operand_reg)
      + $past(first_operand_reg) * $past(second_operand_reg))
      else $error("accumulate result wrong");
   msub_diff_a: assert property (
      go && issue_op == 4'h3 |=> wr_data == $past(accum_operand_reg)
      - $past(first_operand_reg) * $past(second_operand_reg))
      else $error("subtract result wrong");
   nz_flags_a: assert property (
      go && issue_op == 4'h1 |=> flag_nz_we && flag_n == wr_data[W-1]
      && flag_z == (wr_data == '0))
      else $error("negative or zero flag wrong");
   no_flags_a: assert property (
      take && issue_op != 4'h1 |=> !flag_nz_we)
      else $error("flags written by wrong op");
   cond_fail_a: assert property (
      take && !cond_pass |=> !wr_en && !flag_q_set && !flag_nz_we)
      else $error("write after failed condition");
   div_lat_a: assert property (
      go && dv |=> !wr_en ##[1:10] wr_en)
      else $error("divide latency out of range");
   div_hold_a: assert property (
      go && dv |=> !issue_ready ##1 (wr_en || !issue_ready))
      else $error("request accepted during divide");
   div_zero_a: assert property (
      go && dv && second_operand_reg == '0 |-> ##2 wr_en
      && wr_data == '0 && !flag_q_set)
      else $error("divide by zero result wrong");
   dflt_dest_a: assert property (
      go && !dest_given && !dv |=> wr_sel == $past(first_operand_sel))
      else $error("default destination wrong");
   q_only_mac_a: assert property (
      take && issue_op < 4'h6 |=> !flag_q_set)
      else $error("saturation from non-mac op");
   cover property (go && dv && second_operand_reg != '0);
   cover property (flag_q_set);
   cover property (flag_nz_we && flag_z);
endmodule : mdu_unit_checker
bind mdu_unit mdu_unit_checker #(.W(W), .RW(RW)) chk_u (.clk_sys, .resetn,
   .issue_valid, .issue_op, .cond_pass, .dest_given, .dest_sel,
   .first_operand_sel, .first_operand_reg, .second_operand_reg,
   .accum_operand_reg, .issue_ready, .wr_en, .wr_sel, .wr_data,
   .flag_nz_we, .flag_n, .flag_z, .flag_q_set);

// >>> sim/mdu_regfile_model.sv
// Register file model standing behind the unit's write port
`timescale 1ns/10ps
module mdu_regfile_model (
   input  wire logic        clk_sys,
   input  wire logic        resetn,
   input  wire logic        wr_en,
   input  wire logic [3:0]  wr_sel,
   input  wire logic [31:0] wr_data,
   input  wire logic [3:0]  rd_sel,
   output logic [31:0]      rd_data,
   output logic             bad_wr
);
   logic [31:0] regs_reg [16];
   always_ff @(posedge clk_sys) begin
      if (!resetn) begin
         for (int i = 0; i < 16; i++) regs_reg[i] <= '0;
         bad_wr <= 1'b0;
      end else if (wr_en) begin
         regs_reg[wr_sel] <= wr_data;
         // Never named by the issuer, so any write here is stray
         if (wr_sel == mdu_pkg::STACK_POINTER_REG ||
             wr_sel == mdu_pkg::PROGRAM_COUNTER_REG) bad_wr <= 1'b1;
      end
   end
   assign rd_data = regs_reg[rd_sel];
endmodule : mdu_regfile_model

// >>> sim/multiply_divide_unit_tb.sv
// Self-checking bench for the multiply/divide unit
`timescale 1ns/10ps
module multiply_divide_unit_tb;
   typedef struct {
      logic [3:0]  sel;
      logic [31:0] d;
      logic        nz;
      logic        q;
   } mdu_exp_t;
   localparam logic [3:0] D_OP [10] = '{4'h1, 4'h1, 4'h4, 4'h4, 4'h5,
      4'h4, 4'h5, 4'h4, 4'h9, 4'hA};
   localparam logic [31:0] D_A [10] = '{32'h0, 32'hFFFF_0000, 32'h7,
      32'hFFFF_FFF9, 32'hFFFF_FFF9, 32'h5, 32'h5, 32'h8000_0000,
      32'h7FFF_1234, 32'h7FFF_FFFF};
   localparam logic [31:0] D_B [10] = '{32'h1234, 32'h2, 32'h2, 32'h2,
      32'h2, 32'h0, 32'h0, 32'hFFFF_FFFF, 32'h7FFF_5678, 32'h9999_7FFF};
   logic        clk_sys = 1'b0;
   logic        resetn, issue_valid, cond_pass, dest_given, cp, dg;
   logic [3:0]  issue_op, dest_sel, first_operand_sel, wr_sel, rd_sel;
   logic [3:0]  op, ds, fs;
   logic [31:0] first_operand_reg, second_operand_reg, accum_operand_reg;
   logic [31:0] wr_data, rd_data, a, b, c;
   logic        issue_ready, wr_en, flag_nz_we, flag_n, flag_z, flag_q_set;
   logic        bad_wr;
   int          err_total = 0;
   int          check_count = 0;
   int          seed = 65;
   mdu_exp_t    exp_q[$];
   mdu_exp_t    ex;
   logic [31:0] mirror [16] = '{default: 32'h0};
   always #25 clk_sys = ~clk_sys;
   mdu_unit dut_u (.clk_sys, .resetn, .issue_valid, .issue_op, .cond_pass,
      .dest_given, .dest_sel, .first_operand_sel, .first_operand_reg,
      .second_operand_reg, .accum_operand_reg, .issue_ready, .wr_en,
      .wr_sel, .wr_data, .flag_nz_we, .flag_n, .flag_z, .flag_q_set);
   mdu_regfile_model rf_u (.clk_sys, .resetn, .wr_en, .wr_sel, .wr_data,
      .rd_sel, .rd_data, .bad_wr);
   task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp_word
   task automatic cmp_bit(input logic e, input logic g);
      check_count++;
      if (g !== e) begin
         err_total++;
         $display("[ERR] t=%0t exp=%h got=%h", $time, e, g);
      end
   endtask : cmp_bit
   function automatic logic [32:0] ref_calc(input logic [3:0] o,
      input logic [31:0] x1, input logic [31:0] y1, input logic [31:0] z);
      longint s;
      logic [15:0] x;
      logic [15:0] y;
      logic [31:0] r;
      s = 0;
      x = o >= 4'h8 ? x1[31:16] : x1[15:0];
      y = o[0] ? y1[31:16] : y1[15:0];
      case (o)
         4'h0, 4'h1: r = x1 * y1;
         4'h2: r = z + x1 * y1;
         4'h3: r = z - x1 * y1;
         4'h4: r = y1 == 0 ? 32'h0 : (x1 == 32'h8000_0000 && y1 == '1) ?
                   x1 : 32'($signed(x1) / $signed(y1));
         4'h5: r = y1 == 0 ? 32'h0 : x1 / y1;
         4'hA, 4'hB: s = longint'($signed(z))
            + (longint'($signed(x1)) * longint'($signed(y)) >>> 16);
         default: s = longint'($signed(z))
            + longint'($signed(x)) * longint'($signed(y));
      endcase
      if (o >= 4'h6) r = s[31:0];
      return {o >= 4'h6 && s != longint'($signed(s[31:0])), r};
   endfunction : ref_calc
   task automatic issue();
      int n;
      logic [32:0] r;
      n = 0;
      issue_valid <= 1'b1;
      issue_op <= op;
      first_operand_reg <= a;
      second_operand_reg <= b;
      accum_operand_reg <= c;
      cond_pass <= cp;
      dest_given <= dg;
      dest_sel <= ds;
      first_operand_sel <= fs;
      @(negedge clk_sys);
      while (issue_ready !== 1'b1 && n < 20) begin
         @(negedge clk_sys);
         n++;
      end
      if (n == 20) err_total++;
      @(posedge clk_sys);
      r = ref_calc(op, a, b, c);
      if (cp) exp_q.push_back('{dg ? ds : fs, r[31:0], op == 4'h1, r[32]});
   endtask : issue
   task automatic final_report();
      $display("checks=%0d errors=%0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask : final_report
   always @(negedge clk_sys) begin
      if (resetn === 1'b1 && wr_en === 1'b1 && exp_q.size() > 0) begin
         ex = exp_q.pop_front();
         cmp_word(32'(ex.sel), 32'(wr_sel));
         cmp_word(ex.d, wr_data);
         cmp_bit(ex.nz, flag_nz_we);
         if (ex.nz) cmp_bit(ex.d[31], flag_n);
         if (ex.nz) cmp_bit(ex.d == '0, flag_z);
         cmp_bit(ex.q, flag_q_set);
         mirror[ex.sel] = ex.d;
      end else if (resetn === 1'b1)
         cmp_bit(1'b0, wr_en | flag_nz_we | flag_q_set);
   end
   initial begin
      // Well past the longest expected run
      #(50 * 6000);
      err_total++;
      final_report();
   end
   initial begin
      {resetn, issue_valid, cond_pass, dest_given, cp, dg} = '0;
      {issue_op, dest_sel, first_operand_sel, rd_sel} = '0;
      {first_operand_reg, second_operand_reg, accum_operand_reg} = '0;
      repeat (10) @(posedge clk_sys);
      resetn <= 1'b1;
      @(negedge clk_sys);
      cmp_bit(1'b1, issue_ready);
      @(posedge clk_sys);
      {cp, dg} = 2'b11;
      for (int i = 0; i < 10; i++) begin
         {op, a, b, ds, fs} = {D_OP[i], D_A[i], D_B[i], 4'(i), 4'h0};
         c = i < 8 ? 32'h0 : 32'h7FFF_FFFF;
         issue();
      end
      {op, a, b, cp, ds} = {4'h4, 32'd100, 32'd3, 1'b0, 4'h2};
      issue();
      {op, cp, dg, fs} = {4'h0, 1'b1, 1'b0, 4'h3};
      issue();
      for (int i = 0; i < 80; i++) begin
         op = 4'({$random(seed)} % 12);
         a = $random(seed);
         b = 32'($random(seed)) >> ({$random(seed)} % 32);
         c = $random(seed);
         cp = op == 4'h1 || ($random(seed) & 3) != 0;
         dg = op == 4'h1 || ($random(seed) & 1) != 0;
         ds = op == 4'h1 ? 4'($random(seed) & 7)
                         : 4'({$random(seed)} % 13);
         fs = 4'({$random(seed)} % 13);
         issue();
      end
      issue_valid <= 1'b0;
      repeat (14) @(posedge clk_sys);
      cmp_word(32'h0, 32'(exp_q.size()));
      cmp_bit(1'b0, bad_wr);
      for (int i = 0; i < 16; i++) begin
         rd_sel <= 4'(i);
         @(negedge clk_sys);
         cmp_word(mirror[i], rd_data);
         @(posedge clk_sys);
      end
      final_report();
   end
endmodule : multiply_divide_unit_tb
